// ==== src/lta_pkg.sv ====
// shared constants and types of the twisted-pair link adaptation block
// assumes one 125 MHz core clock; all time counts derive from its period
package lta_pkg;

	// core clock period
	localparam int CLK_PERIOD_NS = 8;

	// post-reset configuration sequence length, least time rounded up
	localparam int CFG_TIME_NS = 20000;
	localparam int CFG_CYCLES  = (CFG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CFG_W       = 12;
	localparam logic [11:0] CFG_LAST = 12'(CFG_CYCLES - 1);

	// default crossover hunting slot, a time in ns
	localparam int XOVER_SLOT_NS = 64000;

	// gigabit attempt counter
	localparam int ATT_W = 3;
	localparam logic [2:0] ATT_LIMIT = 3'h3;
	localparam logic [2:0] ATT_MAX   = 3'h7;

	// speed encoding on link_speed
	localparam logic [1:0] SPD_10   = 2'h0;
	localparam logic [1:0] SPD_100  = 2'h1;
	localparam logic [1:0] SPD_1000 = 2'h2;

	// values after reset
	localparam logic XOVER_EN_RST  = 1'h1;
	localparam logic POL_EN_RST    = 1'h1;
	localparam logic ADV_GIG_RST   = 1'h1;
	localparam logic SOFT_FLAG_RST = 1'h1;

	// link-up sequencing phases
	typedef enum logic [2:0] {
		PH_CONFIG,
		PH_IDLE,
		PH_XOVER,
		PH_EXCH,
		PH_UP
	} lta_phase_t;

endpackage

// ==== src/lta_pol.sv ====
// per-pair receive polarity detection, freeze and override
// assumes pulse and polarity observations are already synchronised
`timescale 1ns/10ps
module lta_pol #(
	parameter int PAIRS = 4
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	// link state
	input  wire logic             link_up,
	input  wire logic [1:0]       link_speed,
	input  wire logic             pulse_ok,
	input  wire logic             gb_pol_valid,
	input  wire logic [PAIRS-1:0] pol_obs,
	// control
	input  wire logic             pol_en,
	input  wire logic [PAIRS-1:0] ovr_en,
	input  wire logic [PAIRS-1:0] ovr_val,
	// result, one bit per pair, high means reversed
	output logic      [PAIRS-1:0] status
);

	typedef struct packed {
		logic [PAIRS-1:0] pol;
	} lta_pol_t;

	lta_pol_t         r;
	lta_pol_t         next_r;
	logic [PAIRS-1:0] next_pol;

	// each pair decides on its own
	genvar i;
	generate
		for (i = 0; i < PAIRS; i++)
		begin : g_pair
			always_comb
			begin
				next_pol[i] = r.pol[i];
				if (ovr_en[i])
					next_pol[i] = ovr_val[i];
				else if (!pol_en)
					next_pol[i] = 1'h0;
				else if (!link_up)
				begin
					// link pulses at 10M, training at gigabit, cleared to normal at 100M
					if (link_speed == lta_pkg::SPD_10 && pulse_ok)
						next_pol[i] = pol_obs[i];
					else if (link_speed == lta_pkg::SPD_1000 && gb_pol_valid)
						next_pol[i] = pol_obs[i];
					else if (link_speed == lta_pkg::SPD_100)
						next_pol[i] = 1'h0;
				end
			end
		end
	endgenerate

	always_comb
	begin
		next_r     = r;
		next_r.pol = next_pol;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			r <= '0;
		else
			r <= next_r;
	end

	assign status = r.pol;

	// polarity frozen while the link stays up
	frozen_pol_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(link_up && ovr_en == '0) ##1 (link_up && ovr_en == '0) |-> $stable(r.pol))
		else $error("polarity changed while link up");

	// override value appears one cycle later
	override_pol_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(ovr_en == '1) |=> (r.pol == $past(ovr_val)))
		else $error("polarity override not applied");

endmodule

// ==== src/lta_sync.sv ====
// two-flop synchroniser for levels arriving from the analog front end
// assumes the inputs are levels that hold for several core cycles
`timescale 1ns/10ps
module lta_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	// raw and synchronised levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} lta_sync_t;

	lta_sync_t r;
	lta_sync_t next_r;

	// first stage is read only by the second stage
	always_comb
	begin
		next_r    = r;
		next_r.s1 = d;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			r <= '0;
		else
			r <= next_r;
	end

	assign q = r.s2;

endmodule

// ==== src/lta_top.sv ====
// link adaptation of a multi-speed twisted-pair transceiver: speed
// fallback, pair crossover, polarity and the post-reset configuration
// assumes training and link engine on the same clock; front-end levels async
`timescale 1ns/10ps
module lta_top #(
	parameter int XOVER_SLOT_NS = lta_pkg::XOVER_SLOT_NS
) (
	// clock and hardware reset
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	// management control
	input  wire logic       soft_reset_req,
	input  wire logic       ctl_wr,
	input  wire logic       ctl_xover_en,
	input  wire logic       ctl_pol_en,
	input  wire logic [3:0] pair_polarity_control_en,
	input  wire logic [3:0] pair_polarity_control_val,
	input  wire logic       gbe_only_mode,
	input  wire logic       link_capability_exchange_enable,
	// training and link engine
	input  wire logic       link_up,
	input  wire logic [1:0] link_speed,
	input  wire logic       gb_train_fail,
	input  wire logic       cable_unsuitable,
	input  wire logic       signal_poor,
	input  wire logic       gb_cd_swap,
	input  wire logic       gb_pol_valid,
	// analog front end, asynchronous levels
	input  wire logic       link_pulse_raw,
	input  wire logic [3:0] rx_pol_raw,
	// capability exchange control
	output logic            adv_gig,
	output logic            link_capability_exchange_start,
	output logic            link_restart,
	// pair mapping
	output logic            mdi_ab_cross,
	output logic            mdi_cd_swap,
	// status
	output logic [3:0]      pair_polarity_status,
	output logic            std_control_soft_reset_flag,
	output logic            gigabit_speed_fallback,
	output logic [2:0]      attempt_count,
	output logic            xover_enabled,
	output logic            pol_enabled
);

	// hunting slot, longest time rounded down, never below one cycle
	localparam int SLOT_RAW    = XOVER_SLOT_NS / lta_pkg::CLK_PERIOD_NS;
	localparam int SLOT_CYCLES = (SLOT_RAW < 1) ? 1 : SLOT_RAW;
	localparam int SLOT_W      = $clog2(SLOT_CYCLES + 1);
	localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOT_CYCLES - 1);

	typedef struct packed {
		lta_pkg::lta_phase_t phase;
		logic [lta_pkg::CFG_W-1:0] cfg_cnt;
		logic                      soft_flag;
		logic                      adv_gig;
		logic [lta_pkg::ATT_W-1:0] attempts;
		logic                      fallback;
		logic                      restart;
		logic                      an_start;
		logic                      xover_en;
		logic                      pol_en;
		logic                      ab_cross;
		logic                      cd_swap;
		logic [SLOT_W-1:0]         slot_cnt;
	} lta_top_t;

	localparam lta_top_t RST_STATE = '{
		phase:     lta_pkg::PH_CONFIG,
		cfg_cnt:   '0,
		soft_flag: lta_pkg::SOFT_FLAG_RST,
		adv_gig:   lta_pkg::ADV_GIG_RST,
		attempts:  '0,
		fallback:  1'h0,
		restart:   1'h0,
		an_start:  1'h0,
		xover_en:  lta_pkg::XOVER_EN_RST,
		pol_en:    lta_pkg::POL_EN_RST,
		ab_cross:  1'h0,
		cd_swap:   1'h0,
		slot_cnt:  '0
	};

	lta_top_t   r;
	lta_top_t   next_r;
	logic       pulse_ok;
	logic [3:0] pol_obs;
	logic [3:0] pol_status;
	logic       fb_fire;
	logic       gig_up;

	// front-end levels pass two flops before any logic looks at them
	lta_sync #(
		.W (5)
	) u_sync (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.d       ({link_pulse_raw, rx_pol_raw}),
		.q       ({pulse_ok, pol_obs})
	);

	// per-pair polarity handling
	lta_pol #(
		.PAIRS (4)
	) u_pol (
		.clk_sys      (clk_sys),
		.rst_b        (rst_b),
		.link_up      (link_up),
		.link_speed   (link_speed),
		.pulse_ok     (pulse_ok),
		.gb_pol_valid (gb_pol_valid),
		.pol_obs      (pol_obs),
		.pol_en       (r.pol_en),
		.ovr_en       (pair_polarity_control_en),
		.ovr_val      (pair_polarity_control_val),
		.status       (pol_status)
	);

	assign gig_up = link_up && (link_speed == lta_pkg::SPD_1000);

	// fallback fires only while gigabit is still advertised and the
	// feature is allowed; gigabit-only modes would otherwise never link
	always_comb
	begin
		fb_fire = 1'h0;
		if (!gbe_only_mode && r.adv_gig && r.phase != lta_pkg::PH_CONFIG)
			fb_fire = cable_unsuitable || signal_poor || (r.attempts > lta_pkg::ATT_LIMIT);
	end

	// whole next-state computation
	always_comb
	begin
		next_r          = r;
		next_r.restart  = 1'h0;
		next_r.an_start = 1'h0;

		// enables reset high, software may change them
		if (ctl_wr)
		begin
			next_r.xover_en = ctl_xover_en;
			next_r.pol_en   = ctl_pol_en;
		end

		if (gig_up)
			next_r.attempts = '0;
		else if (gb_train_fail && r.attempts != lta_pkg::ATT_MAX)
			next_r.attempts = r.attempts + 3'h1;

		// withdraw gigabit, force a link drop
		if (fb_fire)
		begin
			next_r.adv_gig  = 1'h0;
			next_r.fallback = 1'h1;
			next_r.restart  = 1'h1;
			next_r.attempts = '0;
			next_r.phase    = lta_pkg::PH_IDLE;
		end

		// gigabit-only modes must always advertise gigabit
		if (gbe_only_mode)
			next_r.adv_gig = 1'h1;

		case (r.phase)
			lta_pkg::PH_CONFIG:
			begin
				next_r.cfg_cnt = r.cfg_cnt + 12'h001;
				if (r.cfg_cnt == lta_pkg::CFG_LAST)
				begin
					next_r.soft_flag = 1'h0;
					next_r.phase     = lta_pkg::PH_IDLE;
				end
			end
			lta_pkg::PH_IDLE:
			begin
				next_r.slot_cnt = '0;
				next_r.cd_swap  = 1'h0;
				if (!fb_fire)
				begin
					if (r.xover_en)
						next_r.phase = lta_pkg::PH_XOVER;
					else
					begin
						next_r.ab_cross = 1'h0;
						next_r.an_start = link_capability_exchange_enable;
						next_r.phase    = lta_pkg::PH_EXCH;
					end
				end
			end
			lta_pkg::PH_XOVER:
			begin
				// valid link pulses lock the A/B mapping
				if (pulse_ok)
				begin
					next_r.an_start = link_capability_exchange_enable;
					next_r.phase    = lta_pkg::PH_EXCH;
				end
				else if (r.slot_cnt == SLOT_LAST)
				begin
					next_r.slot_cnt = '0;
					next_r.ab_cross = !r.ab_cross;
				end
				else
					next_r.slot_cnt = r.slot_cnt + SLOT_W'(1);
				// link partner may also come up with exchange off
				if (link_up)
					next_r.phase = lta_pkg::PH_UP;
			end
			lta_pkg::PH_EXCH:
			begin
				// gigabit training resolves the C/D pairs
				if (link_speed == lta_pkg::SPD_1000 && r.xover_en)
					next_r.cd_swap = gb_cd_swap;
				if (link_up)
					next_r.phase = lta_pkg::PH_UP;
			end
			lta_pkg::PH_UP:
			begin
				if (link_speed != lta_pkg::SPD_1000)
					next_r.cd_swap = 1'h0;
				if (!link_up)
					next_r.phase = lta_pkg::PH_IDLE;
			end
			default:
				next_r.phase = lta_pkg::PH_IDLE;
		endcase

		// soft reset restores link state but not configuration
		if (r.soft_flag && r.phase != lta_pkg::PH_CONFIG)
		begin
			next_r.soft_flag = 1'h0;
			next_r.adv_gig   = lta_pkg::ADV_GIG_RST;
			next_r.fallback  = 1'h0;
			next_r.attempts  = '0;
			next_r.an_start  = 1'h0;
			next_r.restart   = 1'h1;
			next_r.phase     = lta_pkg::PH_IDLE;
		end

		// a new request in the clearing cycle wins over the clear
		if (soft_reset_req)
			next_r.soft_flag = 1'h1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			r <= RST_STATE;
		else
			r <= next_r;
	end

	// all outputs are flop outputs
	assign adv_gig                     = r.adv_gig;
	assign link_capability_exchange_start                  = r.an_start;
	assign link_restart                = r.restart;
	assign mdi_ab_cross                = r.ab_cross;
	assign mdi_cd_swap                 = r.cd_swap;
	assign pair_polarity_status        = pol_status;
	assign std_control_soft_reset_flag = r.soft_flag;
	assign gigabit_speed_fallback      = r.fallback;
	assign attempt_count               = r.attempts;
	assign xover_enabled               = r.xover_en;
	assign pol_enabled                 = r.pol_en;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence cfg_last_s;
		r.phase == lta_pkg::PH_CONFIG && r.cfg_cnt == lta_pkg::CFG_LAST;
	endsequence

	sequence ready_s;
		r.phase == lta_pkg::PH_IDLE && !r.soft_flag;
	endsequence

	sequence soft_seen_s;
		soft_reset_req && r.phase != lta_pkg::PH_CONFIG ##1 !soft_reset_req;
	endsequence

	cfg_ready_flag_a: assert property (cfg_last_s |=> ready_s)
		else $error("reset flag not cleared at configuration end");

	cfg_runs_once_a: assert property (
		r.phase != lta_pkg::PH_CONFIG |=> r.phase != lta_pkg::PH_CONFIG)
		else $error("configuration sequence restarted");

	soft_no_cfg_a: assert property (
		soft_seen_s |=> (r.phase == lta_pkg::PH_IDLE && !r.soft_flag))
		else $error("soft reset mishandled");

	cable_fallback_a: assert property (
		(cable_unsuitable && !gbe_only_mode && r.adv_gig && !r.soft_flag
			&& r.phase != lta_pkg::PH_CONFIG) |=> (!r.adv_gig && r.restart))
		else $error("cabling fallback missing");

	signal_fallback_a: assert property (
		(signal_poor && !gbe_only_mode && r.adv_gig && !r.soft_flag
			&& r.phase != lta_pkg::PH_CONFIG) |=> (!r.adv_gig && r.fallback))
		else $error("signal fallback missing");

	attempt_limit_a: assert property (
		(r.attempts == 3'h4 && !gbe_only_mode && r.adv_gig && !r.soft_flag
			&& r.phase != lta_pkg::PH_CONFIG) |=> !r.adv_gig)
		else $error("attempt limit fallback missing");

	attempt_clear_a: assert property (gig_up |=> r.attempts == '0)
		else $error("attempt counter not cleared");

	attempt_count_a: assert property (
		(gb_train_fail && !gig_up && !fb_fire && !r.soft_flag) |=>
			r.attempts == (($past(r.attempts) == 3'h7) ? 3'h7 : $past(r.attempts) + 3'h1))
		else $error("attempt count wrong");

	gig_only_keep_a: assert property (gbe_only_mode |=> r.adv_gig)
		else $error("gigabit withdrawn in gigabit-only mode");

	gig_stays_off_a: assert property (
		(!r.adv_gig && !r.soft_flag && !gbe_only_mode) |=> !r.adv_gig)
		else $error("gigabit re-advertised after fallback");

	slow_cd_off_a: assert property (
		(r.phase == lta_pkg::PH_UP && link_speed != lta_pkg::SPD_1000) |=> !r.cd_swap)
		else $error("pair swap kept below gigabit");

	xover_first_a: assert property (
		r.an_start |-> ($past(r.phase) == lta_pkg::PH_XOVER || !$past(r.xover_en)))
		else $error("exchange started before crossover");

	reset_enables_a: assert property (
		$rose(rst_b) |-> (r.xover_en && r.pol_en))
		else $error("enables not set after reset");

endmodule

// ==== testbench/lta_partner.sv ====
// link partner at the far end of the cable, seen through the front end
// assumes the bench picks the cable wiring and whether pulses are sent
`timescale 1ns/10ps
module lta_partner (
	// cable and partner set-up from the bench
	input  wire logic       cable_cross,
	input  wire logic       pulses_on,
	input  wire logic [3:0] pol_rev,
	// pair mapping chosen by the block
	input  wire logic       mdi_ab_cross,
	// front-end observations
	output logic            link_pulse_raw,
	output logic [3:0]      rx_pol_raw
);
	// pulses only on matching mapping
	// pulses are heard only once the block has crossed A/B the way the cable is wired
	assign link_pulse_raw = pulses_on && (mdi_ab_cross == cable_cross);
	// per-pair wiring polarity
	// reversal is a property of the wire, so it shows whatever the link state
	assign rx_pol_raw = pol_rev;
endmodule

// ==== testbench/tb_lta_top.sv ====
// self-checking bench for the link adaptation block
// assumes the partner model on the front-end side and a short hunt slot
`timescale 1ns/10ps
module tb_lta_top;
	logic       clk_sys = 1'b0;
	logic       rst_b, soft_reset_req, ctl_wr, ctl_xover_en, ctl_pol_en;
	logic [3:0] pol_en_ovr, pol_val_ovr, pol_rev, pair_polarity_status;
	logic       gbe_only_mode, link_capability_exchange_enable, link_up, gb_train_fail, cable_unsuitable;
	logic       signal_poor, gb_cd_swap, gb_pol_valid, link_pulse_raw, cable_cross, pulses_on;
	logic [3:0] rx_pol_raw;
	logic [1:0] link_speed;
	logic       adv_gig, link_capability_exchange_start, link_restart, mdi_ab_cross, mdi_cd_swap;
	logic       std_control_soft_reset_flag, gigabit_speed_fallback, xover_enabled;
	logic       pol_enabled;
	logic [2:0] attempt_count;
	int         num_errors = 0;
	int         checks = 0;
	int         i;

	// 125 MHz core clock
	always #4 clk_sys = ~clk_sys;

	// slot shortened to ten cycles so hunting stays quick
	lta_top #(.XOVER_SLOT_NS(80)) i_lta_top (
		.clk_sys(clk_sys), .rst_b(rst_b), .soft_reset_req(soft_reset_req), .ctl_wr(ctl_wr),
		.ctl_xover_en(ctl_xover_en), .ctl_pol_en(ctl_pol_en),
		.pair_polarity_control_en(pol_en_ovr), .pair_polarity_control_val(pol_val_ovr),
		.gbe_only_mode(gbe_only_mode), .link_capability_exchange_enable(link_capability_exchange_enable), .link_up(link_up),
		.link_speed(link_speed), .gb_train_fail(gb_train_fail),
		.cable_unsuitable(cable_unsuitable), .signal_poor(signal_poor),
		.gb_cd_swap(gb_cd_swap), .gb_pol_valid(gb_pol_valid),
		.link_pulse_raw(link_pulse_raw), .rx_pol_raw(rx_pol_raw), .adv_gig(adv_gig),
		.link_capability_exchange_start(link_capability_exchange_start), .link_restart(link_restart), .mdi_ab_cross(mdi_ab_cross),
		.mdi_cd_swap(mdi_cd_swap), .pair_polarity_status(pair_polarity_status),
		.std_control_soft_reset_flag(std_control_soft_reset_flag),
		.gigabit_speed_fallback(gigabit_speed_fallback), .attempt_count(attempt_count),
		.xover_enabled(xover_enabled), .pol_enabled(pol_enabled));

	lta_partner i_lta_partner (
		.cable_cross(cable_cross), .pulses_on(pulses_on), .pol_rev(pol_rev),
		.mdi_ab_cross(mdi_ab_cross), .link_pulse_raw(link_pulse_raw),
		.rx_pol_raw(rx_pol_raw));

	// inputs move on the falling edge, outputs are read there too
	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task conclude;
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input logic [3:0] got, input logic [3:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// a wait that ran out is a mismatch and ends the run
	task wait_start;
		for (i = 0; i < 80 && link_capability_exchange_start !== 1'b1; i++)
			cyc(1);
		if (i == 80)
		begin
			num_errors++;
			$display("ERROR %0t ns: no exchange start", $time);
			conclude();
		end
	endtask

	task soft_reset;
		soft_reset_req = 1'b1;
		cyc(1);
		soft_reset_req = 1'b0;
		chk(std_control_soft_reset_flag, 1'b1);
		cyc(1);
		// no second configuration run: ready again at once
		chk({std_control_soft_reset_flag, adv_gig, gigabit_speed_fallback}, 3'h2);
		chk(attempt_count, 3'h0);
	endtask

	// hardware reset, then wait for the configuration run to end
	task hw_reset;
		rst_b = 1'b0;
		cyc(2);
		chk({adv_gig, std_control_soft_reset_flag, xover_enabled, pol_enabled}, 4'hF);
		rst_b = 1'b1;
		for (i = 0; i < 3000 && std_control_soft_reset_flag !== 1'b0; i++)
			cyc(1);
		if (i == 3000)
		begin
			num_errors++;
			$display("ERROR %0t ns: configuration never ended", $time);
			conclude();
		end
		chk({i > 2400, std_control_soft_reset_flag}, 2'h2);
	endtask

	task fail_n(input int n);
		repeat (n)
		begin
			gb_train_fail = 1'b1;
			cyc(1);
			gb_train_fail = 1'b0;
			cyc(1);
		end
	endtask

	task test_xover;
		cable_cross = 1'b1;
		pulses_on = 1'b1;
		wait_start();
		// crossed A/B mapping found before the exchange starts
		chk({mdi_ab_cross, mdi_cd_swap}, 2'h2);
	endtask

	task test_pol;
		pol_rev = 4'hA;
		cyc(4);
		chk(pair_polarity_status, 4'hA);
		link_up = 1'b1;
		pol_rev = 4'h5;
		cyc(4);
		chk(pair_polarity_status, 4'hA);
		pol_en_ovr = 4'hF;
		pol_val_ovr = 4'h3;
		cyc(2);
		chk(pair_polarity_status, 4'h3);
		pol_en_ovr = 4'h0;
		link_speed = 2'h1;
		link_up = 1'b0;
		cyc(4);
		chk(pair_polarity_status, 4'h0);
	endtask

	// every mapping at gigabit, then C/D dropped below gigabit
	task test_maps;
		link_speed = 2'h2;
		gb_pol_valid = 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			cable_cross = m[1];
			gb_cd_swap = m[0];
			link_up = 1'b1;
			cyc(2);
			link_up = 1'b0;
			wait_start();
			cyc(2);
			chk({2'h0, mdi_ab_cross, mdi_cd_swap}, 4'(m));
		end
		chk(pair_polarity_status, 4'h5);
		link_speed = 2'h1;
		link_up = 1'b1;
		cyc(2);
		chk(mdi_cd_swap, 1'b0);
		link_up = 1'b0;
		gb_pol_valid = 1'b0;
	endtask

	task test_fallback(input logic poor);
		cable_unsuitable = ~poor;
		signal_poor = poor;
		cyc(1);
		cable_unsuitable = 1'b0;
		signal_poor = 1'b0;
		chk({adv_gig, gigabit_speed_fallback, link_restart}, 3'h3);
		// the next exchange after the drop starts without gigabit
		wait_start();
		chk({adv_gig, link_restart}, 2'h0);
		soft_reset();
	endtask

	task test_attempts;
		link_speed = 2'h2;
		fail_n(3);
		chk({gigabit_speed_fallback, attempt_count}, 4'h3);
		link_up = 1'b1;
		cyc(2);
		chk(attempt_count, 3'h0);
		link_up = 1'b0;
		fail_n(4);
		chk({gigabit_speed_fallback, adv_gig}, 2'h2);
		soft_reset();
	endtask

	task test_gbe_only;
		gbe_only_mode = 1'b1;
		cable_unsuitable = 1'b1;
		cyc(1);
		cable_unsuitable = 1'b0;
		fail_n(8);
		// counting goes on but saturates, and nothing falls back
		chk({gigabit_speed_fallback, attempt_count}, 4'h7);
		chk(adv_gig, 1'b1);
		gbe_only_mode = 1'b0;
	endtask

	task test_ctl;
		ctl_xover_en = 1'b0;
		ctl_pol_en = 1'b0;
		gb_pol_valid = 1'b1;
		ctl_wr = 1'b1;
		cyc(1);
		ctl_wr = 1'b0;
		cyc(2);
		// reversed pairs are in view, yet correction is off
		chk({xover_enabled, pol_enabled}, 2'h0);
		chk(pair_polarity_status, 4'h0);
		// crossover off: once the link drops again the mapping returns to straight
		link_up = 1'b1;
		cyc(2);
		link_up = 1'b0;
		wait_start();
		chk(mdi_ab_cross, 1'b0);
		// crossover back on with exchange off: hunting runs, no start
		ctl_xover_en = 1'b1;
		link_capability_exchange_enable = 1'b0;
		ctl_wr = 1'b1;
		link_up = 1'b1;
		cyc(1);
		ctl_wr = 1'b0;
		cyc(1);
		link_up = 1'b0;
		repeat (20)
		begin
			cyc(1);
			chk(link_capability_exchange_start, 1'b0);
		end
		chk(mdi_ab_cross, 1'b1);
		link_capability_exchange_enable = 1'b1;
	endtask

	initial
	begin
		{soft_reset_req, ctl_wr, gbe_only_mode, link_up, gb_train_fail} = '0;
		{cable_unsuitable, signal_poor, gb_cd_swap, gb_pol_valid} = '0;
		{cable_cross, pulses_on, pol_rev, pol_en_ovr, pol_val_ovr, link_speed} = '0;
		{ctl_xover_en, ctl_pol_en, link_capability_exchange_enable} = 3'h7;
		hw_reset();
		test_xover();
		test_pol();
		test_maps();
		test_fallback(1'b0);
		test_fallback(1'b1);
		test_attempts();
		test_gbe_only();
		test_ctl();
		// a second hardware reset restores enables and reruns configuration
		hw_reset();
		conclude();
	end
endmodule
